// [design/embedded_ram_block.sv]
// 4 kbit embedded RAM block with separate write and read ports, a
// configuration preload port and selectable organisation and edges.
// Assumes all inputs synchronous to clock; port clocks are sampled levels
// whose active edges are found on clock and act as one-cycle enables.
`timescale 1ns/1ps
`include "ram_block_map.svh"

module embedded_ram_block #(
  parameter ram_block_pkg::org_t  ORG   = ram_block_pkg::ORG_256X16,
  parameter ram_block_pkg::edge_t EDGES = ram_block_pkg::EDGE_RISE_BOTH
) (
  // System
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Write port
  input  wire logic                     wr_clk,
  input  wire logic                     wr_clk_en,
  input  wire logic                     wr_en,
  input  wire logic [`RAM_ADDR_W-1:0]   wr_addr,
  input  wire logic [`RAM_WORD_W-1:0]   wr_data,
  input  wire logic [`RAM_WORD_W-1:0]   wr_mask,
  // Read port
  input  wire logic                     rd_clk,
  input  wire logic                     rd_clk_en,
  input  wire logic                     rd_en,
  input  wire logic [`RAM_ADDR_W-1:0]   rd_addr,
  output logic      [`RAM_WORD_W-1:0]   rd_data,
  // Configuration preload
  input  wire logic                     load_active,
  input  wire logic                     load_valid,
  input  wire logic [`RAM_WORD_AW-1:0]  load_addr,
  input  wire logic [`RAM_WORD_W-1:0]   load_data,
  // Status
  output logic                          user_ready
);

  // Word index: upper address bits above the lane select. Every
  // organisation views the same 256 words, so the narrow lanes of one
  // word are neighbours in the address space.
  function automatic logic [`RAM_WORD_AW-1:0] word_of(
    input logic [`RAM_ADDR_W-1:0] a,
    input ram_block_pkg::org_t    o
  );
    logic [`RAM_ADDR_W-1:0] s;
    s = a >> o;
    return s[`RAM_WORD_AW-1:0];
  endfunction

  // Bit offset of the selected lane inside the 16-bit word
  // Lane 0 always sits at the low end of the word
  function automatic logic [`RAM_OFF_W-1:0] off_of(
    input logic [`RAM_ADDR_W-1:0] a,
    input ram_block_pkg::org_t    o
  );
    logic [`RAM_OFF_W-1:0] r;
    r = '0;
    case (o)
      ram_block_pkg::ORG_256X16: r = 4'h0;
      ram_block_pkg::ORG_512X8:  r = {a[0], 3'h0};
      ram_block_pkg::ORG_1024X4: r = {a[1:0], 2'h0};
      ram_block_pkg::ORG_2048X2: r = {a[2:0], 1'h0};
      default:                   r = 4'h0;
    endcase
    return r;
  endfunction

  // Data bits that one access occupies, before shifting into place
  // Upper bits of narrow write data are simply ignored
  function automatic logic [`RAM_WORD_W-1:0] lanes_of(
    input ram_block_pkg::org_t o
  );
    logic [`RAM_WORD_W-1:0] r;
    r = `RAM_LANES_16;
    case (o)
      ram_block_pkg::ORG_256X16: r = `RAM_LANES_16;
      ram_block_pkg::ORG_512X8:  r = `RAM_LANES_8;
      ram_block_pkg::ORG_1024X4: r = `RAM_LANES_4;
      ram_block_pkg::ORG_2048X2: r = `RAM_LANES_2;
      default:                   r = `RAM_LANES_16;
    endcase
    return r;
  endfunction

  // Active port clock edge of each variant
  // Falling write with rising read is kept for symmetry only
  localparam bit WR_FALL = (EDGES == ram_block_pkg::FALL_WRITE_VARIANT) ||
                           (EDGES == ram_block_pkg::FALL_BOTH_VARIANT);
  localparam bit RD_FALL = (EDGES == ram_block_pkg::FALL_READ_VARIANT) ||
                           (EDGES == ram_block_pkg::FALL_BOTH_VARIANT);

  // Reset copy, port clock edges, write lane mask and read word
  logic                          rst_meta_q;
  logic                          rst_n;
  logic                          wr_edge;
  logic                          rd_edge;
  logic [`RAM_WORD_W-1:0]        wr_lanes;
  logic [`RAM_WORD_W-1:0]        rd_word;
  // Registered state and its next value
  ram_block_pkg::state_t         state_q;
  ram_block_pkg::state_t         state_d;

  // 4 kbit array as 256 words of 16; not reset so a preload survives
  logic [`RAM_WORD_W-1:0] mem [`RAM_WORDS];

  // Reset release through two flops; first flop feeds only the second
  // Assertion acts at once, release waits two edges so that every
  // flop leaves reset in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Active edges of the write and read port clocks
  // Each port clock level must stand a full system clock, or an edge
  // is lost; no filtering is attempted
  pin_edge_pulse #(.FALLING(WR_FALL)) u_wr_edge (
    .clock (clock),
    .rst_n (rst_n),
    .level (wr_clk),
    .pulse (wr_edge)
  );

  pin_edge_pulse #(.FALLING(RD_FALL)) u_rd_edge (
    .clock (clock),
    .rst_n (rst_n),
    .level (rd_clk),
    .pulse (rd_edge)
  );

  // Lanes of a narrow write, placed by the low address bits
  assign wr_lanes = lanes_of(ORG) << off_of(wr_addr, ORG);

  // Word addressed by the registered read stage; the read side has its
  // own address and enables, apart from the write side
  assign rd_word = mem[state_q.rd.word];

  // Next state: input registers, read data and load phase
  // Strobes to the array last one cycle; the rest holds between edges
  always_comb begin
    state_d          = state_q;
    state_d.wr.valid = 1'b0;
    state_d.rd.valid = 1'b0;
    case (state_q.phase)
      ram_block_pkg::PH_LOAD: begin
        // Preload writes whole words; user ports are ignored meanwhile
        if (load_active && load_valid) begin
          state_d.wr.valid  = 1'b1;
          state_d.wr.word   = load_addr;
          state_d.wr.data   = load_data;
          state_d.wr.bit_en = `RAM_LANES_16;
        end
        // The load phase ends for good once load_active is seen low;
        // only a reset brings it back
        if (!load_active) begin
          state_d.phase = ram_block_pkg::PH_USER;
          state_d.ready = 1'b1;
        end
      end
      ram_block_pkg::PH_USER: begin
        // Capture write request at the port edge, both enables high
        if (wr_edge && wr_en && wr_clk_en) begin
          state_d.wr.valid = 1'b1;
          state_d.wr.word  = word_of(wr_addr, ORG);
          state_d.wr.data  = wr_data << off_of(wr_addr, ORG);
          // Mask exists only in the 16-bit organisation; narrow writes
          // touch just their own lane
          if (ORG == ram_block_pkg::ORG_256X16) begin
            state_d.wr.bit_en = ~wr_mask;
          end else begin
            state_d.wr.bit_en = wr_lanes;
          end
        end
        // Capture read address at the port edge, both enables high
        // Array is read in the next cycle from the registered address
        if (rd_edge && rd_en && rd_clk_en) begin
          state_d.rd.valid = 1'b1;
          state_d.rd.word  = word_of(rd_addr, ORG);
          state_d.rd.off   = off_of(rd_addr, ORG);
        end
      end
      default: begin
        state_d.phase = ram_block_pkg::PH_LOAD;
      end
    endcase
    // Read data moves only after a taken read; otherwise it holds
    // Narrow reads come back right-aligned, upper bits zero
    if (state_q.rd.valid) begin
      state_d.rd_data = (rd_word >> state_q.rd.off) & lanes_of(ORG);
    end
  end

  // State register
  // Array is left out so a reset never wipes preloaded contents
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q.phase   <= ram_block_pkg::PH_LOAD;
      state_q.wr      <= '0;
      state_q.rd      <= '0;
      state_q.rd_data <= `RAM_WORD_ZERO;
      state_q.ready   <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Array write from the input registers; masked bits keep old value
  // Write lands one cycle after the port edge; a read of the same word
  // in that cycle still returns the old word
  always_ff @(posedge clock) begin
    if (state_q.wr.valid) begin
      mem[state_q.wr.word] <= (mem[state_q.wr.word] & ~state_q.wr.bit_en) |
                              (state_q.wr.data & state_q.wr.bit_en);
    end
  end

  // Outputs straight from the state register
  assign rd_data    = state_q.rd_data;
  assign user_ready = state_q.ready;

endmodule // embedded_ram_block

// [design/ram_block_map.svh]
// Constants for the 4 kbit embedded RAM block: geometry and field widths.
// Assumes inclusion by the RAM block package and modules; definitions only.
//
// Contract
// - Block stores 4 kbit in a synchronous array.
// - Usable single-port, pseudo dual-port or FIFO storage.
// - Organisations 256x16, 512x8, 1024x4, 2048x2 supported.
// - Mask gates writes only in 16-bit organisation.
// - Clock edges: rise/rise, rise/fall-read, fall/fall variants.
// - Write data and addresses registered at array input.
// - 256x16 write address picks one of 256 words.
// - 256x16 read address picks one of 256 words.
// - Contents optionally preloaded during configuration load.
`ifndef RAM_BLOCK_MAP_SVH
`define RAM_BLOCK_MAP_SVH

`define RAM_TOTAL_BITS 4096
`define RAM_WORDS      256
`define RAM_WORD_W     16
`define RAM_WORD_AW    8
`define RAM_ADDR_W     11
`define RAM_OFF_W      4
`define RAM_LANES_16   16'hffff
`define RAM_LANES_8    16'h00ff
`define RAM_LANES_4    16'h000f
`define RAM_LANES_2    16'h0003
`define RAM_WORD_ZERO  16'h0000

`endif

// [design/ram_block_pkg.sv]
// Types shared by the embedded RAM block: organisation, clock edge
// variant, pipeline stages and the registered state of the top module.
// Assumes ram_block_map.svh is on the include path.
`include "ram_block_map.svh"

package ram_block_pkg;

  typedef enum logic [1:0] {
    ORG_256X16 = 2'h0,
    ORG_512X8  = 2'h1,
    ORG_1024X4 = 2'h2,
    ORG_2048X2 = 2'h3
  } org_t;

  typedef enum logic [1:0] {
    EDGE_RISE_BOTH    = 2'h0,
    FALL_READ_VARIANT = 2'h1,
    FALL_WRITE_VARIANT = 2'h2,
    FALL_BOTH_VARIANT = 2'h3
  } edge_t;

  typedef enum logic [0:0] {
    PH_LOAD = 1'h0,
    PH_USER = 1'h1
  } phase_t;

  typedef struct packed {
    logic                        valid;
    logic [`RAM_WORD_AW-1:0]     word;
    logic [`RAM_WORD_W-1:0]      data;
    logic [`RAM_WORD_W-1:0]      bit_en;
  } wr_stage_t;

  typedef struct packed {
    logic                        valid;
    logic [`RAM_WORD_AW-1:0]     word;
    logic [`RAM_OFF_W-1:0]       off;
  } rd_stage_t;

  typedef struct packed {
    phase_t                      phase;
    wr_stage_t                   wr;
    rd_stage_t                   rd;
    logic [`RAM_WORD_W-1:0]      rd_data;
    logic                        ready;
  } state_t;

endpackage

// [design/pin_edge_pulse.sv]
// Edge detector for a clock-like input sampled on the system clock.
// Assumes the level is synchronous to clock and slower than half its rate.
`timescale 1ns/1ps

module pin_edge_pulse #(
  parameter bit FALLING = 1'b0
) (
  // System
  input  wire logic clock,
  input  wire logic rst_n,
  // Sampled level and detected edge
  input  wire logic level,
  output logic      pulse
);

  logic prev_q;

  // Reset value suppresses a false edge if the level is already idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= ~FALLING;
    end else begin
      prev_q <= level;
    end
  end

  // Chosen polarity of edge
  assign pulse = FALLING ? (prev_q & ~level) : (~prev_q & level);

endmodule // pin_edge_pulse

// [sim/ram_block_properties.sv]
// Checker of the RAM block top ports: load phase, ready and read hold.
// Assumes the rising-edge variant; bound to every embedded_ram_block.
`timescale 1ns/1ps
module ram_block_properties (
  // System
  input wire logic        clock,
  input wire logic        rst_b,
  // Read port, load and status
  input wire logic        rd_clk,
  input wire logic        rd_clk_en,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data,
  input wire logic        load_active,
  input wire logic        user_ready
);
  logic rd_clk_q;
  logic take;
  // Last port clock level; idle high so a quiet clock gives no edge
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) rd_clk_q <= 1'b1;
    else rd_clk_q <= rd_clk;
  // Read taken on a port clock rise with both enables
  assign take = rd_clk && !rd_clk_q && rd_en && rd_clk_en && user_ready;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_quiet; !take ##1 !take ##1 !take; endsequence
  sequence s_sync; !user_ready [*3]; endsequence
  // Reset itself is what this one watches, so it is never disabled
  // Checked from the second low edge, once the async clear has acted
  property p_reset_clear;
    disable iff (1'b0) !rst_b ##1 !rst_b |->
      !user_ready && rd_data == 16'h0000;
  endproperty
  property p_ready_time; $rose(rst_b) && !load_active |-> s_sync ##1
    user_ready; endproperty
  property p_ready_cause; $rose(user_ready) |-> !$past(load_active);
  endproperty
  property p_load_blocks; load_active && !user_ready |=> !user_ready;
  endproperty
  property p_ready_sticky; user_ready |=> user_ready; endproperty
  property p_idle_zero; !user_ready |-> rd_data == 16'h0000; endproperty
  property p_read_hold; s_quiet |=> $stable(rd_data); endproperty
  property p_read_cause; $changed(rd_data) |-> $past(take, 2); endproperty

  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left outputs set");
  a_ready_time: assert property (p_ready_time)
    else $error("ready at wrong edge");
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without load end");
  a_load_blocks: assert property (p_load_blocks)
    else $error("ready during load");
  a_ready_sticky: assert property (p_ready_sticky)
    else $error("ready dropped");
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data before ready");
  a_read_hold: assert property (p_read_hold)
    else $error("read data moved without read");
  a_read_cause: assert property (p_read_cause)
    else $error("read data at wrong edge");
endmodule // ram_block_properties

bind embedded_ram_block ram_block_properties u_ram_block_properties (
  .clock(clock), .rst_b(rst_b), .rd_clk(rd_clk), .rd_clk_en(rd_clk_en),
  .rd_en(rd_en), .rd_data(rd_data), .load_active(load_active),
  .user_ready(user_ready));

// [sim/fabric_user.sv]
// Fabric-side model driving the RAM block's user write and read ports.
// Assumes the bench calls its tasks; inputs change at falling edges.
`timescale 1ns/1ps
module fabric_user (
  // System
  input  wire logic        clock,
  // Write port
  output logic             wr_clk,
  output logic             wr_clk_en,
  output logic             wr_en,
  output logic [10:0]      wr_addr,
  output logic [15:0]      wr_data,
  output logic [15:0]      wr_mask,
  // Read port
  output logic             rd_clk,
  output logic             rd_clk_en,
  output logic             rd_en,
  output logic [10:0]      rd_addr,
  input  wire logic [15:0] rd_data
);
  // Idle: clocks at rest, write controls off so contents stay
  initial begin
    {wr_clk, rd_clk, wr_clk_en, wr_en, rd_clk_en, rd_en} = 6'h30;
    {wr_addr, rd_addr, wr_data, wr_mask} = 54'h0;
  end
  // Lines inverted after release so stale values never pass for good
  task automatic write(input logic [10:0] a, input logic [15:0] d, m,
                       input logic e, ce);
    @(negedge clock) wr_clk = 1'b0;
    @(negedge clock) {wr_clk, wr_en, wr_clk_en} = {1'b1, e, ce};
    {wr_addr, wr_data, wr_mask} = {a, d, m};
    @(negedge clock) {wr_en, wr_clk_en} = 2'h0;
    {wr_addr, wr_data, wr_mask} = ~{a, d, m};
  endtask
  // Data is sampled two edges after the taking edge
  task automatic read(input logic [10:0] a, input logic e,
                      output logic [15:0] q);
    @(negedge clock) rd_clk = 1'b0;
    @(negedge clock) {rd_clk, rd_en, rd_clk_en, rd_addr} = {2'h3, e, a};
    @(negedge clock) {rd_en, rd_clk_en, rd_addr} = {2'h0, ~a};
    repeat (2) @(negedge clock);
    q = rd_data;
  endtask
endmodule // fabric_user

// [sim/tb_top.sv]
// Self-checking bench for the RAM block, 256x16 and 512x8, rising edges.
// Assumes fabric_user drives user ports; the bench owns reset and load.
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        load_active = 1'b1;
  logic        load_valid = 1'b0;
  logic [7:0]  load_addr = 8'h00;
  logic [15:0] load_data = 16'h0000;
  logic        wr_clk, wr_clk_en, wr_en, rd_clk, rd_clk_en, rd_en;
  logic        user_ready;
  logic [10:0] wr_addr, rd_addr;
  logic [15:0] wr_data, wr_mask, rd_data, q;
  logic        narrow_on = 1'b0;
  logic [15:0] rd_data_n;
  int          bad_count = 0;
  int          n_tests = 0;
  always #5 clock = ~clock;
  embedded_ram_block u_embedded_ram_block (.clock, .rst_b, .wr_clk,
    .wr_clk_en, .wr_en, .wr_addr, .wr_data, .wr_mask, .rd_clk, .rd_clk_en,
    .rd_en, .rd_addr, .rd_data, .load_active, .load_valid, .load_addr,
    .load_data, .user_ready);
  fabric_user u_fabric_user (.clock, .wr_clk, .wr_clk_en, .wr_en, .wr_addr,
    .wr_data, .wr_mask, .rd_clk, .rd_clk_en, .rd_en, .rd_addr, .rd_data);
  // Byte-wide twin on the same stimulus; reads only where it was written
  embedded_ram_block #(.ORG(ram_block_pkg::ORG_512X8))
    u_embedded_ram_block_n (.clock, .rst_b, .wr_clk, .wr_clk_en, .wr_en,
    .wr_addr, .wr_data, .wr_mask, .rd_clk,
    .rd_clk_en(rd_clk_en & narrow_on), .rd_en, .rd_addr,
    .rd_data(rd_data_n), .load_active, .load_valid, .load_addr,
    .load_data, .user_ready());
  // Compare and count
  task automatic check(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for the end of the load phase
  task automatic wait_ready;
    for (int i = 0; i < 20 && user_ready !== 1'b1; i++) @(negedge clock);
    check({15'h0, user_ready}, 16'h0001);
  endtask
  task automatic load(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock) {load_valid, load_addr, load_data} = {1'b1, a, d};
    @(negedge clock) {load_valid, load_addr, load_data} = {1'b0, ~a, ~d};
  endtask
  // Preload; a user write inside the load phase must be dropped
  task automatic t_preload;
    repeat (3) @(negedge clock);
    load(8'h10, 16'ha5c3);
    load(8'hff, 16'h1234);
    u_fabric_user.write(11'h010, 16'h0bad, 16'h0000, 1'b1, 1'b1);
    load_active = 1'b0;
    wait_ready();
    u_fabric_user.read(11'h010, 1'b1, q);
    check(q, 16'ha5c3);
    u_fabric_user.read(11'h0ff, 1'b1, q);
    check(q, 16'h1234);
    $display("t_preload done");
  endtask
  // Word 1 and the top word 255, upper address bits ignored, then mask
  task automatic t_write;
    u_fabric_user.write(11'h001, 16'h00ff, 16'h0000, 1'b1, 1'b1);
    u_fabric_user.write(11'h7ff, 16'hbeef, 16'h0000, 1'b1, 1'b1);
    u_fabric_user.write(11'h002, 16'hffff, 16'h0000, 1'b1, 1'b1);
    u_fabric_user.write(11'h002, 16'h0000, 16'hf0f0, 1'b1, 1'b1);
    narrow_on = 1'b1;
    u_fabric_user.read(11'h001, 1'b1, q);
    check(q, 16'h00ff);
    check(rd_data_n, 16'h00ff);
    narrow_on = 1'b0;
    u_fabric_user.read(11'h0ff, 1'b1, q);
    check(q, 16'hbeef);
    narrow_on = 1'b1;
    u_fabric_user.read(11'h002, 1'b1, q);
    check(q, 16'hf0f0);
    check(rd_data_n, 16'h0000);
    $display("t_write done");
  endtask
  // Writes and a read lacking one enable each change nothing
  task automatic t_refuse;
    u_fabric_user.write(11'h002, 16'h5555, 16'h0000, 1'b0, 1'b1);
    u_fabric_user.write(11'h002, 16'haaaa, 16'h0000, 1'b1, 1'b0);
    u_fabric_user.read(11'h001, 1'b0, q);
    check(q, 16'hf0f0);
    check(rd_data_n, 16'h0000);
    u_fabric_user.read(11'h002, 1'b1, q);
    check(q, 16'hf0f0);
    check(rd_data_n, 16'h0000);
    $display("t_refuse done");
  endtask
  // Mid-run reset with no load: contents survive, ready returns
  task automatic t_rereset;
    @(negedge clock) rst_b = 1'b0;
    narrow_on = 1'b0;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    wait_ready();
    u_fabric_user.read(11'h010, 1'b1, q);
    check(q, 16'ha5c3);
    $display("t_rereset done");
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    t_preload();
    t_write();
    t_refuse();
    t_rereset();
    test_done();
  end
  // Watchdog: the tests need about 1 us
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
endmodule // tb_top
